// ---- src/fps_pkg.sv ----
package fps_pkg;
    // ----------------------------------------
    // register indexes, byte address = 4 * index
    // ----------------------------------------
    localparam logic [5:0] IDX_DIV = 6'h00;
    localparam logic [5:0] IDX_CFG = 6'h03;
    localparam logic [5:0] IDX_PROT = 6'h04;
    localparam logic [5:0] IDX_FLAGS = 6'h05;
    localparam logic [5:0] IDX_CMD = 6'h06;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int B_CBE = 7;
    localparam int B_DONEF = 6;
    localparam int B_PROTECT_VIOLATION_FLAG = 5;
    localparam int B_ACCESS_ERROR_FLAG = 4;
    localparam int B_BLANK = 2;
    localparam int B_FAIL = 1;
    localparam int B_DONE = 0;
    localparam int B_CBE_IE = 7;
    localparam int B_DONE_IE = 6;
    localparam int B_DIVLD = 7;
    // ----------------------------------------
    // reset values and constants
    // ----------------------------------------
    localparam logic [7:0] PROT_RST = 8'hff;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] DIV_RST = 8'h00;
    localparam logic [7:0] CMD_VERIFY = 8'h05;
    localparam logic [7:0] CMD_PROG = 8'h20;
    localparam logic [7:0] CMD_SECTOR = 8'h40;
    localparam logic [7:0] CMD_MASS = 8'h41;
    localparam logic [15:0] LOW_BASE = 16'h4000;
    // allowed scenario moves, one row per source, bit = target
    localparam logic [63:0] MOVE_TABLE =
        {8'hff, 8'h5a, 8'h3c, 8'h18, 8'h08, 8'h0c, 8'h0a, 8'h0f};

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ADDR = 2'b01,
        SEQ_CMD = 2'b11
    } fps_seq_t;

    typedef struct packed {
        logic polaritySel;
        logic spare;
        logic highRangeOff;
        logic [1:0] highRangeSize;
        logic lowRangeOff;
        logic [1:0] lowRangeSize;
    } fps_prot_t;

    typedef struct packed {
        logic [7:0] code;
        logic [15:0] addr;
    } fps_launch_t;
endpackage

// ---- src/fps_protect_status.sv ----
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
module fps_protect_status (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // wishbone slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatIn,
    output logic [31:0] wbDatOut,
    output logic wbAck,
    // array side
    input wire logic arrWrite,
    input wire logic [15:0] arrAddr,
    input wire fps_pkg::fps_prot_t protLoad,
    input wire logic specialMode,
    input wire logic cpuStop,
    // command engine
    output logic cmdLaunch,
    output fps_pkg::fps_launch_t launchInfo,
    input wire logic engBufFree,
    input wire logic engAllDone,
    input wire logic engActive,
    input wire logic verifyBlank,
    input wire logic verifyFail,
    // interrupt requests
    output logic irqBufEmpty,
    output logic irqCmdDone
);
    import fps_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    fps_prot_t prot, next_prot;
    logic loaded, next_loaded;
    logic [7:0] cfg, next_cfg;
    logic [7:0] divider, next_divider;
    logic divLoaded, next_divLoaded;
    logic [7:0] cmdCode, next_cmdCode;
    logic [15:0] seqAddr, next_seqAddr;
    fps_seq_t seq, next_seq;
    logic cbe, next_cbe;
    logic cdone, next_cdone;
    logic protect_violation_flag, next_protect_violation_flag;
    logic access_error_flag, next_access_error_flag;
    logic blank, next_blank;
    logic fail, next_fail;
    logic next_launch;
    fps_launch_t next_info;
    logic next_ack;
    logic [31:0] next_dat;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    logic wrReq, wrOk;
    logic [5:0] idx;
    logic [7:0] wd;
    logic [7:0] flagsRd;
    logic [2:0] curScen, newScen;
    fps_prot_t cand;
    logic addrProt;
    logic [15:0] highBase, lowEnd;
    logic blocked;

    assign idx = wbAdr[7:2];
    assign wd = wbDatIn[7:0];
    assign wrReq = wbCyc && wbStb && wbWe && wbAck;
    // only the low lane carries register bits
    assign wrOk = wrReq && wbSel[0];

    // high range always ends at the top of the map
    always_comb begin
        case (prot.highRangeSize)
            2'b00: highBase = 16'hf800;
            2'b01: highBase = 16'hf000;
            2'b10: highBase = 16'he000;
            2'b11: highBase = 16'hc000;
            default: highBase = 16'hc000;
        endcase
        case (prot.lowRangeSize)
            2'b00: lowEnd = 16'h43ff;
            2'b01: lowEnd = 16'h47ff;
            2'b10: lowEnd = 16'h4fff;
            2'b11: lowEnd = 16'h5fff;
            default: lowEnd = 16'h5fff;
        endcase
    end

    always_comb begin
        logic inHigh;
        logic inLow;
        logic hitSel;
        inHigh = !prot.highRangeOff && (seqAddr >= highBase);
        inLow = !prot.lowRangeOff && (seqAddr >= LOW_BASE)
            && (seqAddr <= lowEnd);
        hitSel = inHigh || inLow;
        if (prot.polaritySel) begin
            addrProt = hitSel;
        end else begin
            addrProt = !hitSel;
        end
    end

    assign curScen = {prot.polaritySel, prot.highRangeOff,
        prot.lowRangeOff};

    // size bits follow the write only while their range is off
    always_comb begin
        cand = fps_prot_t'(wd);
        if (!prot.highRangeOff) begin
            cand.highRangeSize = prot.highRangeSize;
        end
        if (!prot.lowRangeOff) begin
            cand.lowRangeSize = prot.lowRangeSize;
        end
    end
    assign newScen = {cand.polaritySel, cand.highRangeOff,
        cand.lowRangeOff};

    assign blocked = access_error_flag || protect_violation_flag || (specialMode && fail);

    always_comb begin
        flagsRd = 8'h00;
        flagsRd[B_CBE] = cbe;
        flagsRd[B_DONEF] = cdone;
        flagsRd[B_PROTECT_VIOLATION_FLAG] = protect_violation_flag;
        flagsRd[B_ACCESS_ERROR_FLAG] = access_error_flag;
        flagsRd[B_BLANK] = blank;
        flagsRd[B_FAIL] = specialMode && fail;
        flagsRd[B_DONE] = specialMode && !engActive;
    end

    // ----------------------------------------
    // bus answer, one cycle after the request
    // ----------------------------------------
    always_comb begin
        next_ack = wbCyc && wbStb && !wbAck;
        next_dat = 32'h0000_0000;
        if (next_ack && !wbWe) begin
            case (idx)
                IDX_DIV: next_dat[7:0] = {divLoaded, divider[6:0]};
                IDX_CFG: next_dat[7:0] = cfg;
                IDX_PROT: next_dat[7:0] = prot;
                IDX_FLAGS: next_dat[7:0] = flagsRd;
                IDX_CMD: next_dat[7:0] = cmdCode;
                default: next_dat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wbAck <= 1'b0;
            wbDatOut <= 32'h0000_0000;
        end else begin
            wbAck <= next_ack;
            wbDatOut <= next_dat;
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_comb begin
        next_prot = prot;
        next_loaded = 1'b1;
        next_cfg = cfg;
        next_divider = divider;
        next_divLoaded = divLoaded;
        if (!loaded) begin
            next_prot = protLoad;
        end else if (wrOk && idx == IDX_PROT
            && MOVE_TABLE[{curScen, newScen}]) begin
            next_prot = cand;
        end
        if (wrOk && idx == IDX_CFG) begin
            next_cfg = wd;
        end
        if (wrOk && idx == IDX_DIV) begin
            next_divider = wd;
            next_divLoaded = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            prot <= PROT_RST;
            loaded <= 1'b0;
            cfg <= CFG_RST;
            divider <= DIV_RST;
            divLoaded <= 1'b0;
        end else begin
            prot <= next_prot;
            loaded <= next_loaded;
            cfg <= next_cfg;
            divider <= next_divider;
            divLoaded <= next_divLoaded;
        end
    end

    // ----------------------------------------
    // command sequence and status flags
    // ----------------------------------------
    always_comb begin
        logic flagWr;
        logic cbeW1;
        logic badCmd;
        logic foreign;
        flagWr = wrOk && idx == IDX_FLAGS;
        cbeW1 = flagWr && wd[B_CBE];
        badCmd = 1'b0;
        foreign = 1'b0;
        next_seq = seq;
        next_cmdCode = cmdCode;
        next_seqAddr = seqAddr;
        next_cbe = cbe;
        next_cdone = cdone;
        next_protect_violation_flag = protect_violation_flag;
        next_access_error_flag = access_error_flag;
        next_blank = blank;
        next_fail = fail;
        next_launch = 1'b0;
        next_info = '{code: cmdCode, addr: seqAddr};
        // buffer, done and blank events first, so a launch clear in the same cycle wins
        if (engBufFree) begin
            next_cbe = 1'b1;
        end
        if (engAllDone) begin
            next_cdone = 1'b1;
        end
        if (verifyBlank) begin
            next_blank = 1'b1;
        end
        if (flagWr && wd[B_PROTECT_VIOLATION_FLAG] && !protect_violation_flag) begin
            next_protect_violation_flag = 1'b0;
        end
        if (flagWr && wd[B_PROTECT_VIOLATION_FLAG]) begin
            next_protect_violation_flag = 1'b0;
        end
        if (flagWr && wd[B_ACCESS_ERROR_FLAG]) begin
            next_access_error_flag = 1'b0;
        end
        if (flagWr && wd[B_FAIL] && specialMode) begin
            next_fail = 1'b0;
        end
        if (verifyFail && specialMode) begin
            next_fail = 1'b1;
        end
        if (cpuStop && !cdone) begin
            next_access_error_flag = 1'b1;
        end
        // any other module write breaks an open sequence
        if (wrOk && idx != IDX_CMD && !flagWr) begin
            foreign = 1'b1;
        end
        case (seq)
            SEQ_IDLE: begin
                if (arrWrite) begin
                    next_seq = SEQ_ADDR;
                    next_seqAddr = arrAddr;
                end else if (wrOk && idx == IDX_CMD) begin
                    next_access_error_flag = 1'b1;
                end
            end
            SEQ_ADDR: begin
                if (wrOk && idx == IDX_CMD) begin
                    badCmd = !(wd == CMD_VERIFY || wd == CMD_PROG
                        || wd == CMD_SECTOR || wd == CMD_MASS);
                    next_cmdCode = wd;
                    next_seq = badCmd ? SEQ_IDLE : SEQ_CMD;
                    if (badCmd) begin
                        next_access_error_flag = 1'b1;
                    end
                end else if (arrWrite || foreign || flagWr) begin
                    next_seq = SEQ_IDLE;
                    next_access_error_flag = 1'b1;
                end
            end
            SEQ_CMD: begin
                if (cbeW1) begin
                    next_seq = SEQ_IDLE;
                    if (blocked) begin
                        next_access_error_flag = 1'b1;
                    end else if (!divLoaded) begin
                        next_access_error_flag = 1'b1;
                    end else if (cmdCode != CMD_VERIFY
                        && cmdCode != CMD_MASS && addrProt) begin
                        next_protect_violation_flag = 1'b1;
                    end else if (cmdCode == CMD_MASS
                        && prot != PROT_RST) begin
                        next_protect_violation_flag = 1'b1;
                    end else begin
                        next_launch = 1'b1;
                        next_cbe = 1'b0;
                        next_cdone = 1'b0;
                        next_blank = 1'b0;
                    end
                end else if (arrWrite || foreign || flagWr
                    || (wrOk && idx == IDX_CMD)) begin
                    next_seq = SEQ_IDLE;
                    next_access_error_flag = 1'b1;
                end
            end
            default: next_seq = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            seq <= SEQ_IDLE;
            cmdCode <= 8'h00;
            seqAddr <= 16'h0000;
            cbe <= 1'b1;
            cdone <= 1'b1;
            protect_violation_flag <= 1'b0;
            access_error_flag <= 1'b0;
            blank <= 1'b0;
            fail <= 1'b0;
            cmdLaunch <= 1'b0;
            launchInfo <= '0;
        end else begin
            seq <= next_seq;
            cmdCode <= next_cmdCode;
            seqAddr <= next_seqAddr;
            cbe <= next_cbe;
            cdone <= next_cdone;
            protect_violation_flag <= next_protect_violation_flag;
            access_error_flag <= next_access_error_flag;
            blank <= next_blank;
            fail <= next_fail;
            cmdLaunch <= next_launch;
            launchInfo <= next_info;
        end
    end

    assign irqBufEmpty = cbe && cfg[B_CBE_IE];
    assign irqCmdDone = cdone && cfg[B_DONE_IE];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic flagW;
    assign flagW = wrOk && idx == IDX_FLAGS;

    bad_move_a: assert property (
        wrOk && idx == IDX_PROT && loaded
        && !MOVE_TABLE[{curScen, newScen}] |=> $stable(prot))
        else $error("disallowed protection move took effect");
    full_lock_a: assert property (
        loaded && curScen == 3'd3 |=> curScen == 3'd3)
        else $error("full protection was loosened");
    launch_clean_a: assert property (
        cmdLaunch |-> $past(!protect_violation_flag && !access_error_flag && divLoaded))
        else $error("launch while blocked");
    launch_flags_a: assert property (
        cmdLaunch && !$past(engBufFree) |-> !cbe && !blank)
        else $error("launch left buffer flag set");
    abort_err_a: assert property (
        seq != SEQ_IDLE && flagW && !wd[B_CBE] |=> access_error_flag)
        else $error("aborted sequence without access error");
    bad_code_a: assert property (
        seq == SEQ_ADDR && wrOk && idx == IDX_CMD && wd != CMD_VERIFY
        && wd != CMD_PROG && wd != CMD_SECTOR && wd != CMD_MASS
        |=> access_error_flag && seq == SEQ_IDLE)
        else $error("illegal code accepted");
    no_div_a: assert property (
        seq == SEQ_CMD && flagW && wd[B_CBE] && !divLoaded
        |=> access_error_flag && !cmdLaunch)
        else $error("launch without divider setting");
    done_set_a: assert property (
        engAllDone |=> cdone)
        else $error("done flag missed completion");
    irq_tie_a: assert property (
        irqBufEmpty == (cbe && cfg[B_CBE_IE]) && (cbe || !irqBufEmpty))
        else $error("buffer interrupt mismatch");
    bus_ack_a: assert property (
        wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck)
        else $error("bus answer not single cycle");
    fail_norm_a: assert property (
        !specialMode |-> !flagsRd[B_FAIL] && !flagsRd[B_DONE])
        else $error("fail or done visible in normal mode");

    seq_launch_c: cover property (seq == SEQ_CMD ##1 cmdLaunch);
    prot_move_c: cover property (curScen == 3'd7 ##1 curScen == 3'd3);
    viol_c: cover property ($rose(protect_violation_flag));
    stop_err_c: cover property (cpuStop && !cdone ##1 access_error_flag);
endmodule

// ---- verification/fps_engine_model.sv ----
`timescale 1ns/1ps
// ----
// command engine stand-in
// ----
module fps_engine_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // block side
    input wire logic cmdLaunch,
    input wire fps_pkg::fps_launch_t launchInfo,
    input wire logic passVerify,
    output logic engBufFree,
    output logic engAllDone,
    output logic engActive,
    output logic verifyBlank,
    output logic verifyFail
);
    import fps_pkg::*;
    int cnt = 0;
    logic isVerify = 1'h0;
    initial begin
        {engBufFree, engAllDone, engActive} = 3'h0;
        {verifyBlank, verifyFail} = 2'h0;
    end
    // one buffer only: no pending command, so done and free pulse together
    always @(posedge clk) begin
        {engBufFree, engAllDone, verifyBlank, verifyFail} <= 4'h0;
        if (!rstn) begin
            cnt <= 0;
            engActive <= 1'h0;
        end else if (cmdLaunch) begin
            cnt <= $urandom_range(15, 8);
            isVerify <= launchInfo.code == CMD_VERIFY;
            engActive <= 1'h1;
        end else if (cnt == 1) begin
            cnt <= 0;
            {engBufFree, engAllDone, engActive} <= 3'h6;
            verifyBlank <= isVerify & passVerify;
            verifyFail <= isVerify & !passVerify;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// ---- verification/flash_protect_and_status_test.sv ----
`timescale 1ns/1ps
module flash_protect_and_status_test;
    import fps_pkg::*;
    logic clk = 1'h0, rstn = 1'h0, wbCyc = 1'h0, wbStb = 1'h0;
    logic wbWe = 1'h0, arrWrite = 1'h0, specialMode = 1'h0;
    logic cpuStop = 1'h0, pass = 1'h1, wbAck, cmdLaunch, engBufFree;
    logic engAllDone, engActive, verifyBlank, verifyFail;
    logic irqBufEmpty, irqCmdDone, f7, f6, f5, f4, f2, f1, divOk, busy;
    logic [7:0] wbAdr = 8'h0, prot, cfg;
    logic [3:0] wbSel = 4'h1;
    logic [31:0] wbDatIn = 32'h0, wbDatOut;
    logic [15:0] arrAddr = 16'h0;
    fps_prot_t protLoad = 8'hff;
    fps_launch_t launchInfo;
    int mismatches = 0, samples_checked = 0;
    logic [63:0] moves = 64'hff5a3c18080c0a0f;
    always #2.5 clk = ~clk;
    fps_protect_status dut (.clk(clk), .rstn(rstn), .wbCyc(wbCyc),
        .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
        .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
        .arrWrite(arrWrite), .arrAddr(arrAddr), .protLoad(protLoad),
        .specialMode(specialMode), .cpuStop(cpuStop),
        .cmdLaunch(cmdLaunch), .launchInfo(launchInfo),
        .engBufFree(engBufFree), .engAllDone(engAllDone),
        .engActive(engActive), .verifyBlank(verifyBlank),
        .verifyFail(verifyFail), .irqBufEmpty(irqBufEmpty),
        .irqCmdDone(irqCmdDone));
    fps_engine_model eng (.clk(clk), .rstn(rstn), .cmdLaunch(cmdLaunch),
        .launchInfo(launchInfo), .passVerify(pass),
        .engBufFree(engBufFree), .engAllDone(engAllDone),
        .engActive(engActive), .verifyBlank(verifyBlank),
        .verifyFail(verifyFail));
    // ----
    // compares and bus cycles
    // ----
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        chk_reg({31'h0, g}, {31'h0, e});
    endtask
    task automatic wb(input logic we, input logic [5:0] i,
                      input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        wbCyc <= 1'h1;
        wbStb <= 1'h1;
        wbWe <= we;
        wbAdr <= {i, 2'($urandom)};
        wbSel <= {3'($urandom), 1'h1};
        wbDatIn <= {24'($urandom), d};
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'h1 && n < 20);
        q = wbDatOut;
        if (n >= 20) mismatches++;
        wbCyc <= 1'h0;
        wbStb <= 1'h0;
    endtask
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        logic [31:0] q;
        wb(1'h1, i, d, q);
    endtask
    task automatic rd_chk(input logic [5:0] i, input logic [31:0] e);
        logic [31:0] q;
        wb(1'h0, i, 8'h0, q);
        chk_reg(q, e);
    endtask
    // ----
    // reference model
    // ----
    function automatic logic [31:0] ef();
        return {24'h0, f7, f6, f5, f4, 1'h0, f2, specialMode & f1,
                specialMode & !busy};
    endfunction
    function automatic int sc(input logic [7:0] p);
        return {p[7], p[5], p[2]};
    endfunction
    function automatic logic hit(input logic [15:0] a);
        logic h, l;
        h = !prot[5] && int'(a) >= 65536 - (2048 << prot[4:3]);
        l = !prot[2] && a >= LOW_BASE
            && int'(a) < 16384 + (1024 << prot[1:0]);
        return prot[7] ? (h | l) : !(h | l);
    endfunction
    task automatic do_reset(input logic [7:0] p);
        @(posedge clk);
        rstn <= 1'h0;
        protLoad <= p;
        repeat (3) @(posedge clk);
        rstn <= 1'h1;
        {f7, f6, f5, f4, f2, f1, divOk, busy} = 8'hc0;
        {prot, cfg} = {p, 8'h0};
    endtask
    task automatic clr();
        wr(IDX_FLAGS, 8'h32);
        {f5, f4} = 2'h0;
        if (specialMode) f1 = 1'h0;
    endtask
    task automatic pulse_arr(input logic [15:0] a);
        @(posedge clk);
        arrAddr <= a;
        arrWrite <= 1'h1;
        @(posedge clk);
        arrWrite <= 1'h0;
    endtask
    task automatic run_cmd(input logic [15:0] a, input logic [7:0] c,
                           input logic stop);
        logic ok, viol;
        int n;
        viol = (c == CMD_MASS) ? prot != 8'hff : c != CMD_VERIFY && hit(a);
        ok = !(f5 | f4 | (specialMode & f1)) && divOk;
        pulse_arr(a);
        wr(IDX_CMD, c);
        wr(IDX_FLAGS, 8'h80);
        @(negedge clk);
        chk_bit(cmdLaunch, ok & !viol);
        if (!ok) f4 = 1'h1;
        else if (viol) f5 = 1'h1;
        else begin
            chk_reg({8'h0, launchInfo}, {8'h0, c, a});
            {f7, f6, f2, busy} = 4'h1;
            rd_chk(IDX_FLAGS, ef());
            if (stop) begin
                @(posedge clk);
                cpuStop <= 1'h1;
                @(posedge clk);
                cpuStop <= 1'h0;
                f4 = 1'h1;
            end
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (engAllDone !== 1'h1 && n < 40);
            if (n >= 40) mismatches++;
            {f7, f6, busy} = 3'h6;
            if (c == CMD_VERIFY && pass) f2 = 1'h1;
            if (c == CMD_VERIFY && !pass && specialMode) f1 = 1'h1;
        end
        rd_chk(IDX_FLAGS, ef());
        chk_bit(irqBufEmpty, f7 & cfg[7]);
        chk_bit(irqCmdDone, f6 & cfg[6]);
    endtask
    task automatic prot_wr(input logic [7:0] d);
        logic [7:0] n;
        n = {d[7], 1'h1, d[5], prot[5] ? d[4:3] : prot[4:3], d[2],
             prot[2] ? d[1:0] : prot[1:0]};
        wr(IDX_PROT, d | 8'h40);
        if (moves[8 * sc(prot) + sc(n)]) prot = n;
        rd_chk(IDX_PROT, {24'h0, prot});
        run_cmd(16'($urandom), CMD_SECTOR, 1'h0);
        clr();
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ----
    // tests
    // ----
    initial begin
        logic [7:0] c;
        logic [31:0] q;
        logic [7:0] cmds [4] = '{CMD_VERIFY, CMD_PROG, CMD_SECTOR, CMD_MASS};
        logic [15:0] edges [10] = '{16'h4000, 16'h4400, 16'h4800,
            16'h5000, 16'h6000, 16'hc000, 16'he000, 16'hf000, 16'hf800,
            16'h0000};
        void'($urandom(88));
        do_reset(8'hff);
        rd_chk(IDX_FLAGS, ef());
        rd_chk(IDX_PROT, 32'hff);
        rd_chk(6'h01, 32'h0);
        run_cmd(16'h8000, CMD_PROG, 1'h0);
        clr();
        wr(IDX_DIV, 8'($urandom));
        divOk = 1'h1;
        wb(1'h0, IDX_DIV, 8'h0, q);
        chk_bit(q[B_DIVLD], 1'h1);
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            cfg = {2'($urandom), 6'h0};
            wr(IDX_CFG, cfg);
            pass = 1'($urandom);
            run_cmd(16'($urandom), cmds[i % 4], i == 5);
            clr();
        end
        for (int i = 0; i < 4; i++) begin
            pulse_arr(16'h8000);
            wr(IDX_CMD, {1'h1, 7'($urandom)});
            f4 = 1'h1;
            rd_chk(IDX_FLAGS, ef());
            clr();
        end
        pulse_arr(16'h8000);
        wr(IDX_FLAGS, 8'h00);
        f4 = 1'h1;
        rd_chk(IDX_FLAGS, ef());
        wr(IDX_FLAGS, 8'h56);
        f4 = 1'h0;
        @(posedge clk);
        cpuStop <= 1'h1;
        @(posedge clk);
        cpuStop <= 1'h0;
        rd_chk(IDX_FLAGS, ef());
        clr();
        rd_chk(IDX_FLAGS, ef());
        $display("test commands done");
        @(posedge clk);
        specialMode <= 1'h1;
        pass = 1'h0;
        clr();
        run_cmd(16'h8000, CMD_VERIFY, 1'h0);
        run_cmd(16'h8000, CMD_PROG, 1'h0);
        wr(IDX_FLAGS, 8'h00);
        rd_chk(IDX_FLAGS, ef());
        clr();
        pass = 1'h1;
        run_cmd(16'h9000, CMD_VERIFY, 1'h0);
        run_cmd(16'h9000, CMD_PROG, 1'h0);
        @(posedge clk);
        specialMode <= 1'h0;
        $display("test special done");
        for (int s = 0; s < 8; s++) begin
            c = {s[2], 1'h1, s[1], 2'($urandom), s[0], 2'($urandom)};
            do_reset(c);
            rd_chk(IDX_PROT, {24'h0, c});
            wr(IDX_DIV, 8'h01);
            divOk = 1'h1;
            for (int k = 0; k < 20; k++) begin
                run_cmd(edges[k / 2] - 16'(2 * (k % 2)), CMD_PROG,
                        1'h0);
                clr();
            end
            run_cmd(16'h8000, CMD_MASS, 1'h0);
            clr();
            repeat (4) prot_wr(8'($urandom));
            $display("test protection %0d done", s);
        end
        test_done();
    end
    initial begin
        #400000;
        mismatches++;
        test_done();
    end
endmodule
